// ==== rtl/nfc_buf_mem.sv ====
// nfc_buf_mem.sv: staging memory for write buffer data.
// assumes one writer and one reader on the same clock.
`timescale 1ns/1ps

module nfc_buf_mem #(
    parameter int DW    = 16,
    parameter int DEPTH = 32,
    parameter int IW    = 5
) (
    input  wire logic          sys_clk,
    input  wire logic          reset,
    input  wire logic          wr_en,
    input  wire logic [IW-1:0] wr_idx,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [IW-1:0] rd_idx,
    output logic      [DW-1:0] rd_data_reg
);
    logic [DW-1:0] mem [DEPTH];

    if (DEPTH > (1 << IW)) begin : g_bad_depth
        $error("nfc_buf_mem: depth exceeds index range");
    end

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rd_data_reg <= '0;
        end else begin
            rd_data_reg <= mem[rd_idx];
        end
    end
endmodule : nfc_buf_mem

// ==== rtl/nfc_cfg.svh ====
// nfc_cfg.svh: constants of the parallel nor flash command host.
// assumes a 50 MHz sys_clk and a flash with a 22-bit address bus.
`ifndef NFC_CFG_SVH
`define NFC_CFG_SVH

// ----------------------------------------------------------------
// bus widths and command addresses
// ----------------------------------------------------------------
`define NFC_AW              22
`define NFC_DW              16
`define NFC_UNLK1_WORD      22'h000555
`define NFC_UNLK2_WORD      22'h0002AA
`define NFC_UNLK1_BYTE      22'h000AAA
`define NFC_UNLK2_BYTE      22'h000555
`define NFC_CFI_WORD        22'h000055
`define NFC_CFI_BYTE        22'h0000AA
`define NFC_ANY_ADDR        22'h000000

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define NFC_CODE_UNLK1      8'hAA
`define NFC_CODE_UNLK2      8'h55
`define NFC_CODE_RESET      8'hF0
`define NFC_CODE_ASEL       8'h90
`define NFC_CODE_PROG       8'hA0
`define NFC_CODE_BUFLOAD    8'h25
`define NFC_CODE_BUFCOMMIT  8'h29
`define NFC_CODE_ERASE      8'h80
`define NFC_CODE_CHIP       8'h10
`define NFC_CODE_SECTOR     8'h30
`define NFC_CODE_RESUME     8'h30
`define NFC_CODE_SUSPEND    8'hB0
`define NFC_CODE_CFI        8'h98

// ----------------------------------------------------------------
// write buffer page limits and sequence steps
// ----------------------------------------------------------------
`define NFC_PAGE_MASK_WORD  6'h0F
`define NFC_PAGE_MASK_BYTE  6'h1F
`define NFC_BUF_DEPTH       32
`define NFC_BUF_FIRST_PAIR  6'h04
`define NFC_BUF_OVERHEAD    6'h06

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define NFC_CLK_NS          20
`define NFC_T_WP_NS         40
`define NFC_T_ACC_NS        100
`define NFC_SYNC_LAT        2
`define NFC_CYC_MIN(ns)     (((ns) + `NFC_CLK_NS - 1) / `NFC_CLK_NS)

`endif

// ==== rtl/nfc_host.sv ====
// nfc_host.sv: host that issues command sequences to a parallel nor
// flash over its chip, write and output enables and address/data pins.
// assumes the user waits for cmd_ready and loads buffer data first.
`timescale 1ns/1ps
`include "nfc_cfg.svh"

module nfc_host
    import nfc_pkg::*;
#(
    parameter int BUF_DEPTH = `NFC_BUF_DEPTH,
    parameter int T_WP_CYC  = `NFC_CYC_MIN(`NFC_T_WP_NS),
    parameter int T_ACC_CYC = `NFC_CYC_MIN(`NFC_T_ACC_NS)
) (
    input  wire logic                sys_clk,
    input  wire logic                reset,
    input  wire logic                byte_mode,
    input  wire logic                cmd_valid,
    input  wire logic [3:0]          cmd_op,
    input  wire logic [`NFC_AW-1:0]  cmd_addr,
    input  wire logic [`NFC_DW-1:0]  cmd_data,
    input  wire logic [4:0]          cmd_count,
    output logic                     cmd_ready,
    output logic                     cmd_error,
    output logic                     rsp_valid,
    output logic      [`NFC_DW-1:0]  rsp_data,
    input  wire logic                buf_wr_en,
    input  wire logic [4:0]          buf_wr_idx,
    input  wire logic [`NFC_DW-1:0]  buf_wr_data,
    output logic      [`NFC_AW-1:0]  flash_addr,
    output logic      [`NFC_DW-1:0]  flash_dq_out,
    output logic                     flash_dq_oe,
    input  wire logic [`NFC_DW-1:0]  flash_dq_in,
    output logic                     flash_ce_n,
    output logic                     flash_we_n,
    output logic                     flash_oe_n
);
    if (BUF_DEPTH < 32 || BUF_DEPTH > 32 || T_WP_CYC < 1 ||
        T_ACC_CYC < 1 || T_ACC_CYC > 250) begin : g_bad_param
        $error("nfc_host: unsupported parameter value");
    end

    // ----------------------------------------------------------------
    // sequence arithmetic
    // ----------------------------------------------------------------
    function automatic logic [5:0] nfc_nwrites(nfc_op_t op,
                                               logic [4:0] c);
        case (op)
            NFC_OP_READ:       nfc_nwrites = 6'h00;
            NFC_OP_ASEL:       nfc_nwrites = 6'h03;
            NFC_OP_ABORT_RST:  nfc_nwrites = 6'h03;
            NFC_OP_PROG:       nfc_nwrites = 6'h04;
            NFC_OP_BUFPROG:    nfc_nwrites = {1'b0, c} + `NFC_BUF_OVERHEAD;
            NFC_OP_CHIP_ERASE: nfc_nwrites = 6'h06;
            NFC_OP_SECT_ERASE: nfc_nwrites = 6'h06;
            default:           nfc_nwrites = 6'h01;
        endcase
    endfunction : nfc_nwrites

    // {address, data} of write cycle st of the sequence
    function automatic logic [37:0] nfc_seq(nfc_op_t op, logic [5:0] st,
        logic bm, logic [21:0] a, logic [15:0] d, logic [4:0] c,
        logic [15:0] bd);
        logic [21:0] u1;
        logic [21:0] u2;
        logic [5:0]  last;
        u1   = bm ? `NFC_UNLK1_BYTE : `NFC_UNLK1_WORD;
        u2   = bm ? `NFC_UNLK2_BYTE : `NFC_UNLK2_WORD;
        last = {1'b0, c} + `NFC_BUF_OVERHEAD - 6'h01;
        case (op)
            NFC_OP_RESET:   nfc_seq = {`NFC_ANY_ADDR, 8'h00,
                                       `NFC_CODE_RESET};
            NFC_OP_SUSPEND: nfc_seq = {`NFC_ANY_ADDR, 8'h00,
                                       `NFC_CODE_SUSPEND};
            NFC_OP_RESUME:  nfc_seq = {`NFC_ANY_ADDR, 8'h00,
                                       `NFC_CODE_RESUME};
            NFC_OP_CFI:     nfc_seq = {bm ? `NFC_CFI_BYTE : `NFC_CFI_WORD,
                                       8'h00, `NFC_CODE_CFI};
            default: begin
                if (st == 6'h00) begin
                    nfc_seq = {u1, 8'h00, `NFC_CODE_UNLK1};
                end else if (st == 6'h01) begin
                    nfc_seq = {u2, 8'h00, `NFC_CODE_UNLK2};
                end else begin
                    case (op)
                        NFC_OP_ASEL:
                            nfc_seq = {u1, 8'h00, `NFC_CODE_ASEL};
                        NFC_OP_ABORT_RST:
                            nfc_seq = {u1, 8'h00, `NFC_CODE_RESET};
                        NFC_OP_PROG:
                            nfc_seq = (st == 6'h02) ?
                                {u1, 8'h00, `NFC_CODE_PROG} : {a, d};
                        NFC_OP_BUFPROG: begin
                            if (st == 6'h02) begin
                                nfc_seq = {a, 8'h00, `NFC_CODE_BUFLOAD};
                            end else if (st == 6'h03) begin
                                nfc_seq = {a, 11'h000, c};
                            end else if (st == last) begin
                                nfc_seq = {a, 8'h00, `NFC_CODE_BUFCOMMIT};
                            end else begin
                                nfc_seq = {a + {16'h0000,
                                    st - `NFC_BUF_FIRST_PAIR}, bd};
                            end
                        end
                        default: begin
                            case (st)
                                6'h02: nfc_seq = {u1, 8'h00,
                                                  `NFC_CODE_ERASE};
                                6'h03: nfc_seq = {u1, 8'h00,
                                                  `NFC_CODE_UNLK1};
                                6'h04: nfc_seq = {u2, 8'h00,
                                                  `NFC_CODE_UNLK2};
                                default: nfc_seq =
                                    (op == NFC_OP_CHIP_ERASE) ?
                                    {u1, 8'h00, `NFC_CODE_CHIP} :
                                    {a, 8'h00, `NFC_CODE_SECTOR};
                            endcase
                        end
                    endcase
                end
            end
        endcase
    endfunction : nfc_seq

    // ----------------------------------------------------------------
    // state and decode
    // ----------------------------------------------------------------
    nfc_state_t         state_reg;
    nfc_state_t         state_next;
    nfc_op_t            op_reg;
    logic [21:0]        addr_reg;
    logic [15:0]        data_reg;
    logic [4:0]         cnt_reg;
    logic               byte_reg;
    logic [5:0]         step_reg;
    logic [7:0]         wait_reg;
    logic [15:0]        dq_s1;
    logic [15:0]        dq_s2;
    logic [15:0]        dq_s3;
    logic [15:0]        buf_rd_data;

    wire nfc_op_t       in_op     = nfc_op_t'(cmd_op);
    wire logic [5:0]    pg_mask   = byte_mode ? `NFC_PAGE_MASK_BYTE :
                                                `NFC_PAGE_MASK_WORD;
    wire logic [5:0]    pg_end    = ({1'b0, cmd_addr[4:0]} & pg_mask) +
                                    {1'b0, cmd_count};
    // a pair beyond the page would make the device abort the load
    wire logic          buf_bad   = (in_op == NFC_OP_BUFPROG) &&
                                    (pg_end > pg_mask);
    wire logic          op_bad    = (cmd_op > 4'(NFC_OP_CFI)) || buf_bad;
    wire logic          take      = (state_reg == NFC_ST_IDLE) &&
                                    cmd_valid && !op_bad;
    wire logic [5:0]    nw        = nfc_nwrites(op_reg, cnt_reg);
    wire logic          last_wr   = (step_reg == nw - 6'h01);
    wire logic          has_read  = (op_reg == NFC_OP_READ) ||
                                    (op_reg == NFC_OP_ASEL);
    wire logic [37:0]   seq_word  = nfc_seq(op_reg, step_reg, byte_reg,
                                    addr_reg, data_reg, cnt_reg,
                                    buf_rd_data);
    wire logic [4:0]    buf_idx   = 5'(step_reg - `NFC_BUF_FIRST_PAIR);
    wire logic          dq_agree  = (dq_s2 == dq_s3);
    wire logic          rd_enter  = (state_next == NFC_ST_RD) &&
                                    (state_reg != NFC_ST_RD);
    wire logic          drive_nx  = (state_next == NFC_ST_SETUP) ||
                                    (state_next == NFC_ST_WLOW) ||
                                    (state_next == NFC_ST_HOLD);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            NFC_ST_IDLE:  if (take) begin
                              state_next = (in_op == NFC_OP_READ) ?
                                  NFC_ST_RD : NFC_ST_PREP;
                          end
            NFC_ST_PREP:  state_next = NFC_ST_SETUP;
            NFC_ST_SETUP: state_next = NFC_ST_WLOW;
            NFC_ST_WLOW:  if (wait_reg == 8'h00) begin
                              state_next = NFC_ST_HOLD;
                          end
            NFC_ST_HOLD:  if (!last_wr) begin
                              state_next = NFC_ST_PREP;
                          end else begin
                              state_next = has_read ? NFC_ST_RGAP :
                                                      NFC_ST_DONE;
                          end
            NFC_ST_RGAP:  state_next = NFC_ST_RD;
            NFC_ST_RD:    if (wait_reg == 8'h00 && dq_agree) begin
                              state_next = NFC_ST_DONE;
                          end
            NFC_ST_DONE:  state_next = NFC_ST_IDLE;
            default:      state_next = NFC_ST_IDLE;
        endcase
    end

    nfc_buf_mem #(.DW(16), .DEPTH(BUF_DEPTH), .IW(5)) u_buf (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .wr_en       (buf_wr_en),
        .wr_idx      (buf_wr_idx),
        .wr_data     (buf_wr_data),
        .rd_idx      (buf_idx),
        .rd_data_reg (buf_rd_data)
    );

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_reg <= NFC_ST_IDLE;
            op_reg    <= NFC_OP_READ;
            addr_reg  <= '0;
            data_reg  <= '0;
            cnt_reg   <= '0;
            byte_reg  <= 1'b0;
            step_reg  <= '0;
            wait_reg  <= '0;
            dq_s1     <= '0;
            dq_s2     <= '0;
            dq_s3     <= '0;
        end else begin
            state_reg <= state_next;
            dq_s1     <= flash_dq_in;
            dq_s2     <= dq_s1;
            dq_s3     <= dq_s2;
            if (take) begin
                op_reg   <= in_op;
                addr_reg <= cmd_addr;
                data_reg <= cmd_data;
                cnt_reg  <= cmd_count;
                byte_reg <= byte_mode;
                step_reg <= '0;
            end else if (state_reg == NFC_ST_HOLD) begin
                step_reg <= step_reg + 6'h01;
            end
            if (state_next == NFC_ST_WLOW && state_reg == NFC_ST_SETUP) begin
                wait_reg <= 8'(T_WP_CYC - 1);
            end else if (rd_enter) begin
                // three-flop input path adds latency before a stable sample
                wait_reg <= 8'(T_ACC_CYC + `NFC_SYNC_LAT);
            end else if (wait_reg != 8'h00) begin
                wait_reg <= wait_reg - 8'h01;
            end
        end
    end

    // pins except flash_dq_out follow state_next so each output comes from a flop
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            flash_ce_n   <= 1'b1;
            flash_we_n   <= 1'b1;
            flash_oe_n   <= 1'b1;
            flash_dq_oe  <= 1'b0;
            flash_addr   <= '0;
            flash_dq_out <= '0;
            cmd_ready    <= 1'b0;
            cmd_error    <= 1'b0;
            rsp_valid    <= 1'b0;
            rsp_data     <= '0;
        end else begin
            flash_ce_n  <= !(drive_nx || state_next == NFC_ST_RD);
            flash_we_n  <= !(state_next == NFC_ST_WLOW);
            flash_oe_n  <= !(state_next == NFC_ST_RD);
            flash_dq_oe <= drive_nx;
            cmd_ready   <= (state_next == NFC_ST_IDLE);
            cmd_error   <= (state_reg == NFC_ST_IDLE) && cmd_valid && op_bad;
            rsp_valid   <= (state_next == NFC_ST_DONE);
            if (state_next == NFC_ST_SETUP) begin
                flash_addr <= seq_word[37:16];
            end else if (rd_enter) begin
                flash_addr <= take ? cmd_addr : addr_reg;
            end
            if (state_reg == NFC_ST_SETUP) begin
                flash_dq_out <= byte_reg ? {8'h00, seq_word[7:0]} :
                                           seq_word[15:0];
            end
            if (state_reg == NFC_ST_RD && state_next == NFC_ST_DONE) begin
                rsp_data <= dq_s3;
            end else if (state_next == NFC_ST_DONE) begin
                rsp_data <= '0;
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    wire logic we_rise_chk = (state_reg == NFC_ST_HOLD);

    a_ce_before_we: assert property (@(posedge sys_clk) disable iff (reset)
        $fell(flash_we_n) |-> $past(!flash_ce_n) && $stable(flash_addr))
        else $error("write enable fell without chip enable");
    a_data_at_rise: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(flash_we_n) |-> $stable(flash_dq_out) && flash_dq_oe &&
        !flash_ce_n)
        else $error("data moved at write enable rise");
    a_read_no_drive: assert property (@(posedge sys_clk) disable iff (reset)
        !flash_oe_n |-> !flash_dq_oe && flash_we_n)
        else $error("bus driven during read");
    a_reset_code: assert property (@(posedge sys_clk) disable iff (reset)
        we_rise_chk && op_reg == NFC_OP_RESET |->
        flash_dq_out[7:0] == `NFC_CODE_RESET)
        else $error("reset write not F0");
    a_unlock_first: assert property (@(posedge sys_clk) disable iff (reset)
        we_rise_chk && step_reg == 6'h00 && nw > 6'h01 |->
        flash_dq_out[7:0] == `NFC_CODE_UNLK1 && flash_addr ==
        (byte_reg ? `NFC_UNLK1_BYTE : `NFC_UNLK1_WORD))
        else $error("first unlock wrong");
    a_asel_then_read: assert property (@(posedge sys_clk) disable iff (reset)
        we_rise_chk && op_reg == NFC_OP_ASEL && last_wr |->
        flash_dq_out[7:0] == `NFC_CODE_ASEL ##2 !flash_oe_n)
        else $error("identifier entry not followed by read");
    a_prog_setup: assert property (@(posedge sys_clk) disable iff (reset)
        we_rise_chk && op_reg == NFC_OP_PROG && step_reg == 6'h02 |->
        flash_dq_out[7:0] == `NFC_CODE_PROG)
        else $error("program setup not A0");
    a_buf_sector: assert property (@(posedge sys_clk) disable iff (reset)
        we_rise_chk && op_reg == NFC_OP_BUFPROG && step_reg == 6'h03 |->
        flash_addr == addr_reg && flash_dq_out[4:0] == cnt_reg)
        else $error("buffer count cycle wrong");
    a_buf_page: assert property (@(posedge sys_clk) disable iff (reset)
        we_rise_chk && op_reg == NFC_OP_BUFPROG && step_reg > 6'h03 |->
        flash_addr[21:5] == addr_reg[21:5])
        else $error("buffered pair left its page");
    a_buf_commit: assert property (@(posedge sys_clk) disable iff (reset)
        we_rise_chk && op_reg == NFC_OP_BUFPROG && last_wr |->
        flash_dq_out[7:0] == `NFC_CODE_BUFCOMMIT && nw <= 6'h25)
        else $error("buffer commit wrong");
    a_erase_last: assert property (@(posedge sys_clk) disable iff (reset)
        we_rise_chk && op_reg == NFC_OP_SECT_ERASE && step_reg == 6'h05 |->
        flash_dq_out[7:0] == `NFC_CODE_SECTOR && flash_addr == addr_reg)
        else $error("sector erase last cycle wrong");
    a_abort_third: assert property (@(posedge sys_clk) disable iff (reset)
        we_rise_chk && op_reg == NFC_OP_ABORT_RST && step_reg == 6'h02 |->
        flash_dq_out[7:0] == `NFC_CODE_RESET)
        else $error("abort reset third cycle wrong");

    c_prog_done: cover property (@(posedge sys_clk) disable iff (reset)
        op_reg == NFC_OP_PROG && rsp_valid);
    c_buf_done: cover property (@(posedge sys_clk) disable iff (reset)
        op_reg == NFC_OP_BUFPROG && rsp_valid);
    c_asel_read: cover property (@(posedge sys_clk) disable iff (reset)
        op_reg == NFC_OP_ASEL && rsp_valid);
endmodule : nfc_host

// ==== rtl/nfc_pkg.sv ====
// nfc_pkg.sv: types of the nor flash command host.
// assumes nfc_cfg.svh holds the numeric constants.
package nfc_pkg;

    // ----------------------------------------------------------------
    // host operations and sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        NFC_OP_READ,
        NFC_OP_RESET,
        NFC_OP_ASEL,
        NFC_OP_PROG,
        NFC_OP_BUFPROG,
        NFC_OP_ABORT_RST,
        NFC_OP_CHIP_ERASE,
        NFC_OP_SECT_ERASE,
        NFC_OP_SUSPEND,
        NFC_OP_RESUME,
        NFC_OP_CFI
    } nfc_op_t;

    typedef enum logic [2:0] {
        NFC_ST_IDLE,
        NFC_ST_PREP,
        NFC_ST_SETUP,
        NFC_ST_WLOW,
        NFC_ST_HOLD,
        NFC_ST_RGAP,
        NFC_ST_RD,
        NFC_ST_DONE
    } nfc_state_t;

endpackage : nfc_pkg

// ==== test/nfc_flash_model.sv ====
// nfc_flash_model.sv: flash partner that logs write cycles, serves reads.
// assumes registered active-low enables from the host.
`timescale 1ns/1ps
module nfc_flash_model (
    input  wire logic [21:0] flash_addr,
    input  wire logic [15:0] flash_dq_out,
    input  wire logic        flash_ce_n,
    input  wire logic        flash_we_n,
    input  wire logic        flash_oe_n,
    output logic      [15:0] flash_dq_in
);
    logic [37:0] log_q[$];
    logic [21:0] addr_lat;
    logic [15:0] arr_val;
    logic [15:0] id_val;
    logic        asel = 1'b0;
    logic        susp = 1'b0;
    logic        ers  = 1'b0;
    logic [8:0]  sect = '0;
    wire         wr_act  = !flash_ce_n && !flash_we_n;
    wire         rd_act  = !flash_ce_n && !flash_oe_n;
    wire         in_susp = susp && (flash_addr[21:13] == sect);
    // ---------------------------------------------------------------
    // mode-aware reads; no stale value on a released bus
    // ---------------------------------------------------------------
    // id and status words are arbitrary; sectors read as unprotected
    assign id_val = (flash_addr[7:0] == 8'h03) ? 16'h0018 :
                    (flash_addr[7:0] == 8'h02) ? 16'h0000 :
                                                 16'h0001;
    assign arr_val = asel ? id_val : in_susp ? 16'h0080 :
                     flash_addr[15:0] ^ 16'h5A3C;
    assign flash_dq_in = rd_act ? arr_val : ~arr_val;
    always @(posedge wr_act) addr_lat = flash_addr;
    always @(negedge wr_act) begin
        log_q.push_back({addr_lat, flash_dq_out});
        case (flash_dq_out[7:0])
            8'h90: asel = 1'b1;
            8'hF0: asel = 1'b0;
            8'hB0: susp = ers;
            8'h30: begin
                if (!susp) {ers, sect} = {1'b1, addr_lat[21:13]};
                susp = 1'b0;
            end
            default: ;
        endcase
    end
endmodule : nfc_flash_model

// ==== test/tb_nor_flash_command_decoder.sv ====
// tb_nor_flash_command_decoder.sv: nfc_host against the flash model.
// assumes nfc_cfg.svh on the include path.
`timescale 1ns/1ps
`include "nfc_cfg.svh"
module tb_nor_flash_command_decoder import nfc_pkg::*;;
    logic sys_clk, reset, byte_mode, cmd_valid, cmd_ready, cmd_error;
    logic rsp_valid, oe, ce_n, we_n, oe_n, buf_we, err_seen;
    logic [3:0] cmd_op;
    logic [4:0] cmd_count, buf_idx;
    logic [21:0] cmd_addr, fa;
    logic [15:0] cmd_data, rsp_data, dq_o, dq_i, buf_d;
    logic [37:0] exp_q[$];
    int fails, compares;
    nfc_host DUT (.sys_clk(sys_clk), .reset(reset), .byte_mode(byte_mode),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .cmd_count(cmd_count), .cmd_ready(cmd_ready),
        .cmd_error(cmd_error), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .buf_wr_en(buf_we), .buf_wr_idx(buf_idx), .buf_wr_data(buf_d),
        .flash_addr(fa), .flash_dq_out(dq_o), .flash_dq_oe(oe),
        .flash_dq_in(dq_i), .flash_ce_n(ce_n), .flash_we_n(we_n),
        .flash_oe_n(oe_n));
    nfc_flash_model u_fl (.flash_addr(fa), .flash_dq_out(dq_o),
        .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
        .flash_dq_in(dq_i));
    task automatic chk(input logic [37:0] seen, input logic [37:0] want);
        compares++;
        if (seen !== want) begin
            fails++;
            $display("MISMATCH %0t: got %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic ex(input logic [21:0] a, input logic [15:0] d);
        exp_q.push_back({a, d});
    endtask : ex
    task automatic unlk();
        ex(byte_mode ? 22'h000AAA : 22'h000555, 16'h00AA);
        ex(byte_mode ? 22'h000555 : 22'h0002AA, 16'h0055);
    endtask : unlk
    // issue one command, then compare the logged write cycles
    task automatic run(input logic [3:0] op, input logic [21:0] a);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1) begin
            @(posedge sys_clk);
            #1;
        end
        u_fl.log_q.delete();
        {cmd_op, cmd_addr, cmd_valid} = {op, a, 1'b1};
        @(posedge sys_clk);
        #1 cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && cmd_error !== 1'b1 && n < 300) begin
            @(posedge sys_clk);
            #1 n++;
        end
        err_seen = cmd_error;
        chk(38'(n < 300), 38'(1));
        chk(38'(u_fl.log_q.size()), 38'(exp_q.size()));
        foreach (exp_q[i]) chk(u_fl.log_q[i], exp_q[i]);
        exp_q.delete();
        @(posedge sys_clk);
        #1;
    endtask : run
    task automatic t_read();
        run(NFC_OP_READ, 22'h2ABCDE);
        chk(38'(rsp_data), 38'(16'hBCDE ^ 16'h5A3C));
        for (int k = 0; k < 3; k++) begin
            unlk();
            ex(22'h000555, 16'h0090);
            run(NFC_OP_ASEL, k == 0 ? 22'h000003 :
                             k == 1 ? 22'h000001 : 22'h3FE002);
            chk(38'(rsp_data), k == 0 ? 38'h18 : 38'(k == 1));
        end
        $display("test read done");
    endtask : t_read
    task automatic t_single();
        ex(22'h0, 16'h00F0);
        run(NFC_OP_RESET, 22'h0);
        run(NFC_OP_READ, 22'h000003);
        chk(38'(rsp_data), 38'(16'h0003 ^ 16'h5A3C));
        unlk();
        ex(22'h000555, 16'h00A0);
        ex(22'h3F0010, 16'hBEEF);
        cmd_data = 16'hBEEF;
        run(NFC_OP_PROG, 22'h3F0010);
        unlk();
        ex(22'h000555, 16'h00F0);
        run(NFC_OP_ABORT_RST, 22'h0);
        $display("test single done");
    endtask : t_single
    task automatic t_buf();
        for (int b = 0; b < 2; b++) begin
            byte_mode = b[0];
            cmd_count = b ? 5'h1F : 5'h0F;
            for (int i = 0; i < 32; i++) begin
                {buf_we, buf_idx, buf_d} = {1'b1, 5'(i), 16'hA5C0 + 16'(i)};
                @(posedge sys_clk);
                #1;
            end
            buf_we = 1'b0;
            unlk();
            ex(22'h001240, 16'h0025);
            ex(22'h001240, {11'h000, cmd_count});
            for (int i = 0; i <= int'(cmd_count); i++)
                ex(22'h001240 + 22'(i), (b ? 16'h00C0 : 16'hA5C0) + 16'(i));
            ex(22'h001240, 16'h0029);
            run(NFC_OP_BUFPROG, 22'h001240);
            chk(38'(u_fl.log_q.size()), b ? 38'd37 : 38'd21);
        end
        $display("test buffer done");
    endtask : t_buf
    task automatic t_erase();
        for (int b = 1; b >= 0; b--) begin
            byte_mode = b[0];
            unlk();
            ex(b ? 22'h000AAA : 22'h000555, 16'h0080);
            unlk();
            ex(b ? 22'h000AAA : 22'h3FE000, b ? 16'h0010 : 16'h0030);
            run(b ? NFC_OP_CHIP_ERASE : NFC_OP_SECT_ERASE, 22'h3FE000);
            ex(b ? 22'h0000AA : 22'h000055, 16'h0098);
            run(NFC_OP_CFI, 22'h0);
        end
        ex(22'h0, 16'h00B0);
        run(NFC_OP_SUSPEND, 22'h0);
        run(NFC_OP_READ, 22'h3FE123);
        chk(38'(rsp_data), 38'(16'h0080));
        run(NFC_OP_READ, 22'h1FE123);
        chk(38'(rsp_data), 38'(16'hE123 ^ 16'h5A3C));
        ex(22'h0, 16'h0030);
        run(NFC_OP_RESUME, 22'h0);
        run(NFC_OP_READ, 22'h3FE123);
        chk(38'(rsp_data), 38'(16'hE123 ^ 16'h5A3C));
        $display("test erase done");
    endtask : t_erase
    task automatic t_refuse();
        run(4'hB, 22'h0);
        chk(38'(err_seen), 38'(1));
        cmd_count = 5'h0F;
        run(NFC_OP_BUFPROG, 22'h000001);
        chk(38'(err_seen), 38'(1));
        $display("test refuse done");
    endtask : t_refuse
    task automatic results();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        {reset, cmd_valid, byte_mode, cmd_op, cmd_addr} = {3'b100, 26'h0};
        {cmd_data, cmd_count, buf_we, buf_idx, buf_d} = 43'h0;
        repeat (12) @(posedge sys_clk);
        #1 reset = 1'b0;
        t_read();
        t_single();
        t_buf();
        t_erase();
        t_refuse();
        results();
    end
    initial begin
        #400000;
        fails++;
        results();
    end
endmodule : tb_nor_flash_command_decoder
